/* logic/pxio_core.sv */
// Port expander I/O core: open-drain ports with latched change detection,
// push-pull outputs, change alert, address-select power-up defaults, standby.
// Assumes a serial slave beside it that reports accesses and host writes.
// What this block does
// - Latch input changes until next clearing event
// - Eight change flags, set on input change
// - Clear all flags on any access outside serial reset, except edges seen in that same cycle
// - Drive alert low while change detected
// - Host-written port levels raise no alert
// - Release alert on next access outside serial reset, unless an edge is seen in that same cycle
// - Pullups enabled in groups of four
// - Pullup groups default high, others low
// - Push-pull power-up levels in groups of four
// - Reset detection and release alert
// - Clear all change flags at reset
// - Load sixteen port defaults from selects
// - Power-on reset restores all defaults
// - Serial reset abandons transaction, forces stop
// - Serial reset leaves alert unchanged
// - Standby when idle, wake on activity
// - Low select for ports 0-3, high for 4-7
// - Select high means pullup and default high
// - Decode address afresh on every transmission
//
// The address map and the strobed register port were left to the implementer.
module pxio_core
   import pxio_pkg::*;
#(
   parameter int NUM_IO = PXIO_NUM_IO,
   parameter int NUM_OUT = PXIO_NUM_OUT
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Pins from outside the clock domain
   input wire logic addr_select_low,
   input wire logic addr_select_high,
   input wire logic serRst_b,
   input wire logic [NUM_IO-1:0] ioPinIn,
   // Serial slave side, same clock domain
   input wire logic serAccess,
   input wire logic busStart,
   input wire logic busStop,
   input wire logic ioWrite,
   input wire logic [NUM_IO-1:0] ioWriteData,
   input wire logic outWrite,
   input wire logic [NUM_OUT-1:0] outWriteData,
   // Open-drain ports
   output logic [NUM_IO-1:0] ioPinOut,
   output logic [NUM_IO-1:0] ioPinOe_b,
   output logic [NUM_IO-1:0] pullupEn,
   // Push-pull outputs
   output logic [NUM_OUT-1:0] outPin,
   // Status to slave and pins
   output logic [NUM_IO-1:0] ioReadData,
   output logic [NUM_IO-1:0] changeFlags,
   output logic alert_b,
   output logic serAbort,
   output logic standby,
   output logic [1:0] addrSelect
);
   // Expand the two select levels into per-port group masks
   function automatic logic [NUM_IO-1:0] groupMask(input logic lo, input logic hi);
      logic [NUM_IO-1:0] m;
      m = '0;
      for (int i = 0; i < NUM_IO; i++) begin
         m[i] = (i < PXIO_GROUP) ? lo : hi;
      end
      return m;
   endfunction

   // Same split for the push-pull bank, whose width may differ
   function automatic logic [NUM_OUT-1:0] outGroupMask(input logic lo, input logic hi);
      logic [NUM_OUT-1:0] m;
      m = '0;
      for (int i = 0; i < NUM_OUT; i++) begin
         m[i] = (i < PXIO_GROUP) ? lo : hi;
      end
      return m;
   endfunction

   // A host request counts only while the serial reset is not held
   function automatic logic taken(input logic req, input logic rstOn);
      return req && !rstOn;
   endfunction

   logic [NUM_IO-1:0] ioSync;
   logic [2:0] ctlSync;
   logic selLo;
   logic selHi;
   logic serRstSync_b;
   logic serRstOn;

   pxio_sync #(.WIDTH(NUM_IO), .INIT('1)) u_io_sync (
      .clock(clock),
      .rst_b(rst_b),
      .asyncIn(ioPinIn),
      .syncOut(ioSync)
   );

   // Selects idle high, as an undecoded bus line reads high
   pxio_sync #(.WIDTH(3), .INIT(3'h7)) u_ctl_sync (
      .clock(clock),
      .rst_b(rst_b),
      .asyncIn({serRst_b, addr_select_high, addr_select_low}),
      .syncOut(ctlSync)
   );

   assign selLo = ctlSync[0];
   assign selHi = ctlSync[1];
   assign serRstSync_b = ctlSync[2];
   assign serRstOn = (serRstSync_b == PXIO_SER_RST_ACTIVE);

   // Power-up load waits until the select synchroniser has filled
   localparam logic [1:0] SETTLE_LOAD = 2'(PXIO_SYNC_STAGES);
   localparam logic [1:0] SETTLE_DONE = 2'(PXIO_SYNC_STAGES + 1);
   // Host-driven pin levels need the synchroniser delay plus one edge
   localparam logic [1:0] QUIET_LEN = 2'(PXIO_SYNC_STAGES + 1);

   // Configuration group: select latch, pullups and power-up load
   logic [1:0] settleCnt;
   logic [1:0] next_settleCnt;
   logic loadDefaults;
   logic [NUM_IO-1:0] next_pullupEn;
   logic [1:0] next_addrSelect;

   // The synchronisers sit at their reset level for two edges after release,
   // so a load in the first cycle would miss the real select pins
   always_comb begin
      loadDefaults = (settleCnt == SETTLE_LOAD);
      next_settleCnt = settleCnt;
      if (settleCnt != SETTLE_DONE) begin
         next_settleCnt = settleCnt + 2'h1;
      end
      next_addrSelect = addrSelect;
      next_pullupEn = pullupEn;
      // Select pins are re-sampled at every bus start
      if (busStart || loadDefaults) begin
         next_addrSelect = {selHi, selLo};
         next_pullupEn = groupMask(selLo, selHi);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         settleCnt <= 2'h0;
         pullupEn <= '1;
         addrSelect <= 2'h3;
      end else begin
         settleCnt <= next_settleCnt;
         pullupEn <= next_pullupEn;
         addrSelect <= next_addrSelect;
      end
   end

   // Port group: open-drain latch and push-pull outputs
   logic [NUM_IO-1:0] next_ioPinOut;
   logic [NUM_IO-1:0] next_ioPinOe_b;
   logic [NUM_OUT-1:0] next_outPin;

   always_comb begin
      next_ioPinOut = ioPinOut;
      next_outPin = outPin;
      // Until the load all ports stay released and outputs high
      if (loadDefaults) begin
         next_ioPinOut = groupMask(selLo, selHi);
         next_outPin = outGroupMask(selLo, selHi);
      end
      // A write in the load cycle wins over the defaults
      if (taken(ioWrite, serRstOn)) begin
         next_ioPinOut = ioWriteData;
      end
      if (taken(outWrite, serRstOn)) begin
         next_outPin = outWriteData;
      end
      // Open-drain: zero drives low, one releases
      next_ioPinOe_b = next_ioPinOut;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ioPinOut <= '1;
         ioPinOe_b <= '1;
         outPin <= '1;
      end else begin
         ioPinOut <= next_ioPinOut;
         ioPinOe_b <= next_ioPinOe_b;
         outPin <= next_outPin;
      end
   end

   // Change group: reference levels, sticky flags and alert
   logic [NUM_IO-1:0] next_ioReadData;
   logic [NUM_IO-1:0] next_changeFlags;
   logic next_alert_b;
   logic [NUM_IO-1:0] refLevel;
   logic [NUM_IO-1:0] next_refLevel;
   logic [NUM_IO-1:0] prevLevel;
   logic [NUM_IO-1:0] next_prevLevel;
   logic [1:0] quietCnt;
   logic [1:0] next_quietCnt;
   logic [NUM_IO-1:0] inputMask;
   logic [NUM_IO-1:0] diff;
   logic [NUM_IO-1:0] freshEdge;
   logic quiet;
   logic accessOn;

   // While a host-driven level crosses the synchroniser the reference simply
   // follows the pins; a real input change inside that short window is lost.
   // That is the price of never alerting on the host's own writes.
   always_comb begin
      accessOn = taken(serAccess, serRstOn);
      quiet = (quietCnt != 2'h0);
      // Only released ports act as inputs; a low-driven port ignores its pin
      inputMask = ioPinOut;
      diff = '0;
      freshEdge = '0;
      if (!quiet) begin
         diff = (ioSync ^ refLevel) & inputMask;
         // Edge seen in this very cycle; it survives a clearing access
         freshEdge = (ioSync ^ prevLevel) & inputMask;
      end
      next_prevLevel = ioSync;
      next_ioReadData = ioSync;
      next_refLevel = refLevel;
      next_quietCnt = quiet ? (quietCnt - 2'h1) : 2'h0;
      if (loadDefaults || taken(ioWrite, serRstOn)) begin
         next_quietCnt = QUIET_LEN;
      end
      if (quiet || accessOn || loadDefaults) begin
         next_refLevel = ioSync;
      end
      next_changeFlags = changeFlags | diff;
      next_alert_b = alert_b;
      // Alert follows the flags; serial reset only blocks the access
      if (accessOn) begin
         next_changeFlags = freshEdge;
         next_alert_b = (freshEdge == '0) ? PXIO_ALERT_RELEASED : 1'h0;
      end else if (next_changeFlags != '0) begin
         next_alert_b = 1'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ioReadData <= '1;
         changeFlags <= PXIO_FLAGS_CLEAR;
         alert_b <= PXIO_ALERT_RELEASED;
         refLevel <= '1;
         prevLevel <= '1;
         quietCnt <= 2'h0;
      end else begin
         ioReadData <= next_ioReadData;
         changeFlags <= next_changeFlags;
         alert_b <= next_alert_b;
         refLevel <= next_refLevel;
         prevLevel <= next_prevLevel;
         quietCnt <= next_quietCnt;
      end
   end

   // Link group: serial abort and automatic standby
   pxio_link_e linkState;
   pxio_link_e next_linkState;
   logic next_serAbort;
   logic next_standby;

   // Standby is left only by a start; a stop or serial reset drops to idle,
   // and idle falls into standby on the next cycle unless a start arrives
   always_comb begin
      next_serAbort = serRstOn;
      next_linkState = linkState;
      case (linkState)
         PXIO_IDLE: begin
            // A start right behind a stop must not be lost on the way down
            next_linkState = taken(busStart, serRstOn) ? PXIO_ACTIVE : PXIO_STANDBY;
         end
         PXIO_STANDBY: begin
            if (taken(busStart, serRstOn)) begin
               next_linkState = PXIO_ACTIVE;
            end
         end
         PXIO_ACTIVE: begin
            if (busStop || serRstOn) begin
               next_linkState = PXIO_IDLE;
            end
         end
         default: begin
            next_linkState = PXIO_IDLE;
         end
      endcase
      next_standby = (next_linkState == PXIO_STANDBY);
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         serAbort <= 1'h0;
         standby <= 1'h0;
         linkState <= PXIO_IDLE;
      end else begin
         serAbort <= next_serAbort;
         standby <= next_standby;
         linkState <= next_linkState;
      end
   end
endmodule // pxio_core

/* logic/pxio_pkg.sv */
// Package for the port expander I/O core: widths, groups and reset levels.
// Assumes a single 50 MHz clock and a synchronous active-low reset.
package pxio_pkg;
   localparam int PXIO_NUM_IO = 8;
   localparam int PXIO_NUM_OUT = 8;
   localparam int PXIO_GROUP = 4;
   localparam int PXIO_SYNC_STAGES = 2;
   localparam logic PXIO_ALERT_RELEASED = 1'h1;
   localparam logic [7:0] PXIO_FLAGS_CLEAR = 8'h00;
   // Serial reset level that forces the link back to its stop state
   localparam logic PXIO_SER_RST_ACTIVE = 1'h0;
   typedef enum logic [1:0] {PXIO_IDLE, PXIO_ACTIVE, PXIO_STANDBY} pxio_link_e;
endpackage

/* logic/pxio_sync.sv */
// Two flip-flop synchroniser for a bus of pins from outside the clock domain.
// Assumes the first stage is read only by the second.
module pxio_sync #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Data
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_syncOut;

   always_comb begin
      next_stage1 = asyncIn;
      next_syncOut = stage1;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         stage1 <= INIT;
         syncOut <= INIT;
      end else begin
         stage1 <= next_stage1;
         syncOut <= next_syncOut;
      end
   end
endmodule // pxio_sync

/* verif/pxio_core_props.sv */
// Checker for the port expander core, bound to each instance.
// Assumes one clock and sees only the core's ports.
module pxio_core_props #(parameter int NUM_IO = 8) (
   // Clock, resets and serial side
   input wire logic clock, rst_b, serRst_b, serAccess, busStart, busStop, ioWrite,
   input wire logic [NUM_IO-1:0] ioWriteData, changeFlags, ioPinOut, ioPinOe_b,
   input wire logic alert_b, serAbort, standby
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // One cycle of slack for idle before standby
   sequence stopQuiet;
      busStop && !busStart ##1 !busStart [*3];
   endsequence
   a_alert_flags: assert property (alert_b == ~|changeFlags)
      else $error("alert off flags");
   a_flag_sticky: assert property (|changeFlags && !serAccess |=>
      (changeFlags & $past(changeFlags)) == $past(changeFlags)) else $error("flag lost");
   a_write_port: assert property (ioWrite && !serAbort |=>
      ioPinOut == $past(ioWriteData)) else $error("write lost");
   a_oe_follow: assert property (ioPinOe_b == ioPinOut) else $error("bad enable");
   a_abort_alert: assert property ($rose(serAbort) |=> $stable(alert_b))
      else $error("alert moved");
   a_abort_level: assert property (!serRst_b [*4] |-> serAbort)
      else $error("no abort");
   a_standby_wake: assert property (busStart && !serAbort |-> ##[1:2] !standby)
      else $error("no wake");
   a_standby_idle: assert property (stopQuiet |-> standby) else $error("no standby");
endmodule // pxio_core_props
bind pxio_core pxio_core_props #(.NUM_IO(NUM_IO)) chk (.*);

/* verif/pxio_host.sv */
// Stand-in for the serial slave and its master, as pulses.
// Assumes frame is entered just after a rising clock edge.
module pxio_host (
   input wire logic clock,
   // Transaction pulses and write data
   output logic serAccess, busStart, busStop, ioWrite, outWrite,
   output logic [7:0] ioWriteData, outWriteData
);
   initial {serAccess, busStart, busStop, ioWrite, outWrite, ioWriteData, outWriteData} = '0;
   // Eight clocks make one 160 ns bit; bits sets how slowly a frame runs
   task automatic frame(input logic [1:0] wr, input logic [7:0] d, input int bits);
      busStart <= 1'h1;
      @(posedge clock) busStart <= 1'h0;
      repeat (8 * bits) @(posedge clock);
      serAccess <= 1'h1;
      {outWrite, ioWrite} <= wr;
      {outWriteData, ioWriteData} <= {d, d};
      @(posedge clock) {serAccess, outWrite, ioWrite} <= 3'h0;
      // Released data must not keep showing the last byte
      {outWriteData, ioWriteData} <= ~{d, d};
      repeat (8) @(posedge clock);
      busStop <= 1'h1;
      @(posedge clock) busStop <= 1'h0;
      repeat (4) @(posedge clock);
   endtask
endmodule // pxio_host

/* verif/test_pxio_core.sv */
// Self-checking bench for the port expander core.
// Assumes pxio_host stands in for the serial slave and its master.
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin errorCnt++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_pxio_core
   import pxio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'h0, rst_b = 1'h0, serRst_b = 1'h1;
   logic addr_select_low = 1'h1, addr_select_high = 1'h1;
   logic [7:0] extIn = 8'hff;
   int errorCnt = 0, checksDone = 0;
   wire logic serAccess, busStart, busStop, ioWrite, outWrite, alert_b, serAbort, standby;
   wire logic [7:0] ioWriteData, outWriteData, ioPinOut, ioPinOe_b, pullupEn, outPin;
   wire logic [7:0] changeFlags, ioReadData;
   wire logic [1:0] addrSelect;
   // The core only pulls low; otherwise the outside level shows
   wire logic [7:0] ioPinIn = extIn & ioPinOe_b;
   pxio_core DUT (.*);
   pxio_host host (.*);
   always #10 clock = ~clock;
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic closeOut();
      $display("errors=%0d checks=%0d", errorCnt, checksDone);
      if (errorCnt == 0 && checksDone > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Each select pattern needs its own power-on reset
   task automatic checkDefaults();
      logic [7:0] exp;
      for (int i = 0; i < 4; i++) begin
         {addr_select_high, addr_select_low} <= 2'(i);
         rst_b <= 1'h0;
         tick(4);
         rst_b <= 1'h1;
         tick(4);
         exp = {{4{addr_select_high}}, {4{addr_select_low}}};
         `CHK(addrSelect, {addr_select_high, addr_select_low})
         `CHK(ioPinOut, exp)
         `CHK(pullupEn, exp)
         `CHK(outPin, exp)
         `CHK(changeFlags, PXIO_FLAGS_CLEAR)
         `CHK(alert_b, PXIO_ALERT_RELEASED)
      end
   endtask
   // A one-cycle glitch must stay recorded
   task automatic checkChange();
      extIn <= 8'hfb;
      tick(1);
      extIn <= 8'hff;
      tick(6);
      `CHK(changeFlags, 8'h04)
      `CHK(ioReadData, 8'hff)
      `CHK(alert_b, 1'h0)
      host.frame(2'h0, 8'h00, 1);
      `CHK(changeFlags, PXIO_FLAGS_CLEAR)
      `CHK(alert_b, PXIO_ALERT_RELEASED)
   endtask
   task automatic checkHostWrite();
      host.frame(2'h1, 8'h7e, 1);
      `CHK(ioPinOe_b, 8'h7e)
      `CHK(alert_b, PXIO_ALERT_RELEASED)
      host.frame(2'h3, 8'hff, 2);
      `CHK(ioPinOut, 8'hff)
      `CHK(changeFlags, PXIO_FLAGS_CLEAR)
   endtask
   task automatic checkSerialReset();
      extIn <= 8'hef;
      tick(6);
      serRst_b <= 1'h0;
      tick(6);
      `CHK(serAbort, 1'h1)
      `CHK(alert_b, 1'h0)
      serRst_b <= 1'h1;
      tick(6);
      `CHK(serAbort, 1'h0)
      `CHK(alert_b, 1'h0)
      `CHK(standby, 1'h1)
      host.frame(2'h0, 8'h00, 3);
      `CHK(alert_b, PXIO_ALERT_RELEASED)
   endtask
   initial begin
      tick(12);
      checkDefaults();
      checkChange();
      checkHostWrite();
      checkSerialReset();
      closeOut();
   end
   // The tests need well under two thousand cycles
   initial begin
      tick(20000);
      errorCnt++;
      closeOut();
   end
endmodule // test_pxio_core
